// >>> rtl/port_led_fifo_cfg.v
// per-port indicator and fifo configuration register with receive error counter
`timescale 1ns/1ps
`include "port_led_defs.vh"

module port_led_fifo_cfg #(
    parameter [`FLASH_CNT_W-1:0] FLASH_HALF_CYCLES = `IND_FLASH_CYCLES
) (
    input  wire                   sys_clk,
    input  wire                   rst_n,
    // management register port
    input  wire [`REG_ADDR_W-1:0] regAddr,
    input  wire                   regWrEn,
    input  wire                   regRdEn,
    input  wire [`REG_DATA_W-1:0] regWrData,
    output reg  [`REG_DATA_W-1:0] regRdData,
    output reg                    regRdValid,
    // port status from the transceiver
    input  wire                   speed100,
    input  wire                   bicolorMode,
    input  wire                   carrierSense,
    input  wire                   rxDataValid,
    input  wire                   linkStatus,
    input  wire                   activityStatus,
    input  wire                   speedStatus,
    input  wire                   duplexStatus,
    // events
    input  wire                   rxErrorEvent,
    input  wire                   falseCarrierEvent,
    input  wire                   disconnectEvent,
    input  wire                   disconnectFlagRead,
    // outputs
    output reg                    rxCarrierValidOut,
    output wire                   fifoDepthSelect,
    output wire [5:0]             fifoDepth,
    output reg                    linkIndicator,
    output reg                    activityIndicator,
    output reg                    speedIndicator,
    output reg                    duplexIndicator,
    output reg                    disconnectFlag
);

    ////////////////////////////////////////////////////////////////////////////
    // register decode

    reg  [`CFG_USED_W-1:0] cfg;
    reg                    countMode8;

    // true when a strobe hits the given register address
    function addr_hit;
        input                   strobe;
        input [`REG_ADDR_W-1:0] addr;
        input [`REG_ADDR_W-1:0] target;
        begin
            addr_hit = strobe && (addr == target);
        end
    endfunction

    wire cfgWrite = addr_hit(regWrEn, regAddr, `REG_CFG_ADDR);
    wire cntWrite = addr_hit(regWrEn, regAddr, `REG_CNT_ADDR);
    wire cntRead  = addr_hit(regRdEn, regAddr, `REG_CNT_ADDR);

    // named configuration fields
    wire gatedCarrierValidEnable = cfg[`CFG_GATED_CRS_BIT];
    wire autoModeDisable         = cfg[`CFG_AUTO_MODE_BIT];
    wire activityIndFlash        = cfg[`CFG_ACT_FLASH_BIT];
    wire linkIndFlash            = cfg[`CFG_LINK_FLASH_BIT];
    wire duplexIndForceOn        = cfg[`CFG_DUP_ON_BIT];
    wire duplexIndForceOff       = cfg[`CFG_DUP_OFF_BIT];
    wire activityIndForceOn      = cfg[`CFG_ACT_ON_BIT];
    wire activityIndForceOff     = cfg[`CFG_ACT_OFF_BIT];
    wire speedIndForceOn         = cfg[`CFG_SPD_ON_BIT];
    wire speedIndForceOff        = cfg[`CFG_SPD_OFF_BIT];
    wire linkIndForceOn          = cfg[`CFG_LINK_ON_BIT];
    wire linkIndForceOff         = cfg[`CFG_LINK_OFF_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // configuration and counter mode registers

    // configuration bits reset to zero; only the low bits are stored
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            cfg <= `CFG_RESET;
        else if (cfgWrite)
            cfg <= regWrData[`CFG_USED_W-1:0];
    end

    // counter mode is write-only and resets to 16-bit counting
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            countMode8 <= `CNT_MODE_RESET;
        else if (cntWrite)
            countMode8 <= regWrData[`CNT_MODE_BIT];
    end

    ////////////////////////////////////////////////////////////////////////////
    // disconnect flag, latched high until the status read

    wire discEvent100 = disconnectEvent && speed100;

    // set wins over a clearing read in the same cycle
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            disconnectFlag <= 1'b0;
        else if (discEvent100)
            disconnectFlag <= 1'b1;
        else if (disconnectFlagRead)
            disconnectFlag <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // receive error counters

    wire [`CNT16_W-1:0] count16;
    wire [`CNT8_W-1:0]  count8;
    wire [`CNT4_W-1:0]  falseCarrierCount;
    wire [`CNT4_W-1:0]  disconnectCount;

    // sixteen-bit error count, active in 16-bit mode
    sat_counter #(
        .WIDTH (`CNT16_W)
    ) u_count16 (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .inc     (rxErrorEvent && !countMode8),
        .clear   (cntRead),
        .value   (count16)
    );

    // eight-bit error count, active in 8-bit mode
    sat_counter #(
        .WIDTH (`CNT8_W)
    ) u_count8 (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .inc     (rxErrorEvent && countMode8),
        .clear   (cntRead),
        .value   (count8)
    );

    // false carrier count, 8-bit mode only
    sat_counter #(
        .WIDTH (`CNT4_W)
    ) u_false_carrier (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .inc     (falseCarrierEvent && countMode8),
        .clear   (cntRead),
        .value   (falseCarrierCount)
    );

    // disconnect count fed by the 100M disconnect events that set the flag, 8-bit mode only
    sat_counter #(
        .WIDTH (`CNT4_W)
    ) u_disconnect (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .inc     (discEvent100 && countMode8),
        .clear   (cntRead),
        .value   (disconnectCount)
    );

    // counter register view for the selected mode
    wire [`REG_DATA_W-1:0] counterView = countMode8 ?
        {disconnectCount, falseCarrierCount, count8} : count16;

    ////////////////////////////////////////////////////////////////////////////
    // read port

    reg [`REG_DATA_W-1:0] next_regRdData;

    // read mux; unmapped addresses and reserved bits read as zero
    always @*
    begin
        next_regRdData = {`REG_DATA_W{1'b0}};
        case (regAddr)
            `REG_CFG_ADDR: next_regRdData = {3'h0, cfg};
            `REG_CNT_ADDR: next_regRdData = counterView;
            default:       next_regRdData = {`REG_DATA_W{1'b0}};
        endcase
    end

    // capture the value in the same cycle that the counters clear
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            regRdData  <= {`REG_DATA_W{1'b0}};
            regRdValid <= 1'b0;
        end
        else
        begin
            regRdValid <= regRdEn;
            if (regRdEn)
                regRdData <= next_regRdData;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // carrier valid and fifo depth

    // gated mode at 100M only passes carrier while data is valid
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            rxCarrierValidOut <= 1'b0;
        else if (gatedCarrierValidEnable && speed100)
            rxCarrierValidOut <= carrierSense && rxDataValid;
        else
            rxCarrierValidOut <= carrierSense;
    end

    assign fifoDepthSelect = cfg[`CFG_FIFO_DEPTH_BIT];
    reg [5:0] depthWord;

    // depth word is loaded with the depth bit so the output comes from a flip-flop
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            depthWord <= `FIFO_DEPTH_NORMAL;
        else if (cfgWrite)
            depthWord <= regWrData[`CFG_FIFO_DEPTH_BIT] ? `FIFO_DEPTH_REDUCED :
                                                          `FIFO_DEPTH_NORMAL;
    end

    assign fifoDepth       = depthWord;

    ////////////////////////////////////////////////////////////////////////////
    // indicator drive

    wire forcedBicolor = bicolorMode && autoModeDisable;
    wire autoBicolor   = bicolorMode && !autoModeDisable;
    wire flashRun      = forcedBicolor && (activityIndFlash || linkIndFlash);
    wire flashPhase;

    // shared 320 ms phase generator
    flash_timer #(
        .HALF_CYCLES (FLASH_HALF_CYCLES)
    ) u_flash (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .run     (flashRun),
        .phase   (flashPhase)
    );

    // apply a force pair; force on overrides force off
    function force_pair;
        input base;
        input forceOn;
        input forceOff;
        begin
            if (forceOn)
                force_pair = 1'b1;
            else if (forceOff)
                force_pair = 1'b0;
            else
                force_pair = base;
        end
    endfunction

    reg baseLink;
    reg baseActivity;

    // bicolor mode shaping ahead of the force overrides
    always @*
    begin
        baseLink     = linkStatus;
        baseActivity = activityStatus;
        if (autoBicolor && activityStatus)
            baseLink = 1'b0;
        if (forcedBicolor && activityIndFlash)
            baseActivity = flashPhase;
        if (forcedBicolor && linkIndFlash)
            baseLink = flashPhase;
    end

    reg next_linkIndicator;
    reg next_activityIndicator;
    reg next_speedIndicator;
    reg next_duplexIndicator;

    // force overrides on top of the shaped status; force on beats force off
    always @*
    begin
        next_duplexIndicator   = force_pair(duplexStatus, duplexIndForceOn,
                                            duplexIndForceOff);
        next_activityIndicator = force_pair(baseActivity, activityIndForceOn,
                                            activityIndForceOff);
        next_speedIndicator    = force_pair(speedStatus, speedIndForceOn,
                                            speedIndForceOff);
        next_linkIndicator     = force_pair(baseLink, linkIndForceOn,
                                            linkIndForceOff);
    end

    // registered indicator outputs
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            linkIndicator     <= 1'b0;
            activityIndicator <= 1'b0;
            speedIndicator    <= 1'b0;
            duplexIndicator   <= 1'b0;
        end
        else
        begin
            duplexIndicator   <= next_duplexIndicator;
            activityIndicator <= next_activityIndicator;
            speedIndicator    <= next_speedIndicator;
            linkIndicator     <= next_linkIndicator;
        end
    end

endmodule // port_led_fifo_cfg

// >>> shared/port_led_defs.vh
// constants for the per-port indicator, fifo configuration and receive error counter block
`ifndef PORT_LED_DEFS_VH
`define PORT_LED_DEFS_VH

// register addresses on the management port
`define REG_ADDR_W          5
`define REG_CFG_ADDR        5'h14
`define REG_CNT_ADDR        5'h15
`define REG_DATA_W          16

// configuration register fields
`define CFG_GATED_CRS_BIT   12
`define CFG_FIFO_DEPTH_BIT  11
`define CFG_AUTO_MODE_BIT   10
`define CFG_ACT_FLASH_BIT   9
`define CFG_LINK_FLASH_BIT  8
`define CFG_DUP_ON_BIT      7
`define CFG_DUP_OFF_BIT     6
`define CFG_ACT_ON_BIT      5
`define CFG_ACT_OFF_BIT     4
`define CFG_SPD_ON_BIT      3
`define CFG_SPD_OFF_BIT     2
`define CFG_LINK_ON_BIT     1
`define CFG_LINK_OFF_BIT    0
`define CFG_USED_W          13
`define CFG_RESET           13'h0000

// counter register fields
`define CNT_MODE_BIT        0
`define CNT_MODE_RESET      1'b0
`define CNT8_W              8
`define CNT4_W              4
`define CNT16_W             16

// fifo depths in bits
`define FIFO_DEPTH_NORMAL   6'h20
`define FIFO_DEPTH_REDUCED  6'h10

// indicator flash timing
`define SYS_CLK_MHZ         200
`define IND_FLASH_MS        320
`define IND_FLASH_CYCLES    26'h3D0_9000 // 320 ms at 200 MHz, sized to the flash counter
`define FLASH_CNT_W         26

`endif

// >>> rtl/flash_timer.v
// half-period divider that toggles the indicator flash phase
`timescale 1ns/1ps
`include "port_led_defs.vh"

module flash_timer #(
    parameter [`FLASH_CNT_W-1:0] HALF_CYCLES = `IND_FLASH_CYCLES
) (
    input  wire sys_clk,
    input  wire rst_n,
    input  wire run,
    output reg  phase
);

    reg [`FLASH_CNT_W-1:0] count;

    // count one half period, then flip the phase; idle holds phase high
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count <= {`FLASH_CNT_W{1'b0}};
            phase <= 1'b1;
        end
        else if (!run)
        begin
            count <= {`FLASH_CNT_W{1'b0}};
            phase <= 1'b1;
        end
        else if (count == HALF_CYCLES - 1'b1)
        begin
            count <= {`FLASH_CNT_W{1'b0}};
            phase <= ~phase;
        end
        else
        begin
            count <= count + 1'b1;
        end
    end

endmodule // flash_timer

// >>> rtl/sat_counter.v
// saturating event counter with a clear that never loses a same-cycle event
`timescale 1ns/1ps

module sat_counter #(
    parameter WIDTH = 8
) (
    input  wire             sys_clk,
    input  wire             rst_n,
    input  wire             inc,
    input  wire             clear,
    output reg  [WIDTH-1:0] value
);

    // add one unless already all ones
    function [WIDTH-1:0] sat_inc;
        input [WIDTH-1:0] v;
        begin
            sat_inc = (&v) ? v : v + 1'b1;
        end
    endfunction

    // a clear with an event in the same cycle restarts at one
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            value <= {WIDTH{1'b0}};
        else if (clear)
            value <= inc ? {{(WIDTH-1){1'b0}}, 1'b1} : {WIDTH{1'b0}};
        else if (inc)
            value <= sat_inc(value);
    end

endmodule // sat_counter

// >>> dv/port_led_fifo_cfg_assertions.sv
// concurrent checks on the indicator, fifo and counter register block
`timescale 1ns/1ps
`include "port_led_defs.vh"

module port_led_fifo_cfg_assertions (
    input wire                   sys_clk,
    input wire                   rst_n,
    input wire [`REG_ADDR_W-1:0] regAddr,
    input wire                   regWrEn,
    input wire                   regRdEn,
    input wire [`REG_DATA_W-1:0] regWrData,
    input wire [`REG_DATA_W-1:0] regRdData,
    input wire                   regRdValid,
    input wire                   speed100,
    input wire                   bicolorMode,
    input wire                   carrierSense,
    input wire                   rxDataValid,
    input wire                   activityStatus,
    input wire                   disconnectEvent,
    input wire                   rxCarrierValidOut,
    input wire                   fifoDepthSelect,
    input wire [5:0]             fifoDepth,
    input wire                   linkIndicator,
    input wire                   activityIndicator,
    input wire                   speedIndicator,
    input wire                   duplexIndicator,
    input wire                   disconnectFlag
);
    reg [12:0] cfg;

    ////////////////////////////////////////////////////////////////////////////////
    // shadow of the configuration register built from observed writes
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            cfg <= 13'h0000;
        else if (regWrEn && regAddr == `REG_CFG_ADDR)
            cfg <= regWrData[12:0];
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////////////
    // register port, carrier output and fifo depth
    property p_cfgRead;
        regRdEn && regAddr == `REG_CFG_ADDR |=> regRdValid && regRdData == {3'h0, cfg};
    endproperty
    a_cfgRead: assert property (p_cfgRead) else $error("config readback wrong");
    property p_crsdv;
        $past(rst_n) |-> rxCarrierValidOut ==
            $past(carrierSense & ((cfg[12] & speed100) ? rxDataValid : 1'b1));
    endproperty
    a_crsdv: assert property (p_crsdv) else $error("carrier valid output wrong");
    property p_fifo;
        fifoDepthSelect == cfg[11] && fifoDepth == (fifoDepthSelect ? 6'h10 : 6'h20);
    endproperty
    a_fifo: assert property (p_fifo) else $error("fifo depth wrong");

    ////////////////////////////////////////////////////////////////////////////////
    // indicator overrides, bicolor shaping and disconnect flag latch
    property p_dupForce;
        $past(cfg[7] | cfg[6]) |-> duplexIndicator == $past(cfg[7]);
    endproperty
    a_dupForce: assert property (p_dupForce) else $error("duplex force wrong");
    property p_actForce;
        $past(cfg[5] | cfg[4]) |-> activityIndicator == $past(cfg[5]);
    endproperty
    a_actForce: assert property (p_actForce) else $error("activity force wrong");
    property p_spdForce;
        $past(cfg[3] | cfg[2]) |-> speedIndicator == $past(cfg[3]);
    endproperty
    a_spdForce: assert property (p_spdForce) else $error("speed force wrong");
    property p_linkForce;
        $past(cfg[1] | cfg[0]) |-> linkIndicator == $past(cfg[1]);
    endproperty
    a_linkForce: assert property (p_linkForce) else $error("link force wrong");
    property p_autoBicolor;
        $past(bicolorMode && !cfg[10] && activityStatus && !cfg[1]) |-> !linkIndicator;
    endproperty
    a_autoBicolor: assert property (p_autoBicolor) else $error("link not low");
    property p_discFlag;
        disconnectEvent && speed100 |=> disconnectFlag;
    endproperty
    a_discFlag: assert property (p_discFlag) else $error("flag not latched");
endmodule // port_led_fifo_cfg_assertions

// >>> dv/mgmt_model.sv
// management controller model that reads and writes the register port
`timescale 1ns/1ps

module mgmt_model (
    input  wire        sys_clk,
    output reg  [4:0]  regAddr,
    output reg         regWrEn,
    output reg         regRdEn,
    output reg  [15:0] regWrData,
    input  wire [15:0] regRdData,
    input  wire        regRdValid
);
    initial
    begin
        regAddr = 5'h00;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regWrData = 16'h0000;
    end

    // one-cycle write strobe; address and data scrambled once released
    task wr(input [4:0] a, input [15:0] d);
    begin
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge sys_clk);
        regWrEn <= 1'b0;
        regAddr <= ~a;
        regWrData <= ~d;
    end
    endtask

    // one-cycle read strobe, then a bounded wait for the answer
    task rd(input [4:0] a, output [15:0] d, output ok);
        integer i;
    begin
        ok = 1'b0;
        d = 16'h0000;
        @(posedge sys_clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge sys_clk);
        regRdEn <= 1'b0;
        regAddr <= ~a;
        for (i = 0; i < 4 && !ok; i = i + 1)
        begin
            @(posedge sys_clk);
            if (regRdValid === 1'b1)
            begin
                ok = 1'b1;
                d = regRdData;
            end
        end
    end
    endtask
endmodule // mgmt_model

// >>> dv/tb_top.sv
// self-checking bench for the indicator, fifo and counter register block
`timescale 1ns/1ps

module tb_top;
    reg         sys_clk, rst_n, speed100, bicolorMode, carrierSense, rxDataValid;
    reg         linkStatus, activityStatus, speedStatus, duplexStatus;
    reg         rxErrorEvent, falseCarrierEvent, disconnectEvent, disconnectFlagRead;
    wire [4:0]  regAddr;
    wire [15:0] regWrData, regRdData;
    wire [5:0]  fifoDepth;
    wire        regWrEn, regRdEn, regRdValid, rxCarrierValidOut, fifoDepthSelect;
    wire        linkIndicator, activityIndicator, speedIndicator, duplexIndicator;
    wire        disconnectFlag;
    reg  [31:0] r, rc;
    reg  [15:0] d, c;
    reg         ok;
    integer     n_errors, n_checks, i, er, fc, dc, na, nl;

    port_led_fifo_cfg #(.FLASH_HALF_CYCLES(26'd8)) dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .regAddr(regAddr), .regWrEn(regWrEn), .regRdEn(regRdEn), .regWrData(regWrData),
        .regRdData(regRdData), .regRdValid(regRdValid), .speed100(speed100),
        .bicolorMode(bicolorMode), .carrierSense(carrierSense), .rxDataValid(rxDataValid),
        .linkStatus(linkStatus), .activityStatus(activityStatus), .speedStatus(speedStatus),
        .duplexStatus(duplexStatus), .rxErrorEvent(rxErrorEvent),
        .falseCarrierEvent(falseCarrierEvent), .disconnectEvent(disconnectEvent),
        .disconnectFlagRead(disconnectFlagRead), .rxCarrierValidOut(rxCarrierValidOut),
        .fifoDepthSelect(fifoDepthSelect), .fifoDepth(fifoDepth),
        .linkIndicator(linkIndicator), .activityIndicator(activityIndicator),
        .speedIndicator(speedIndicator), .duplexIndicator(duplexIndicator),
        .disconnectFlag(disconnectFlag));

    mgmt_model mm (.sys_clk(sys_clk), .regAddr(regAddr), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData),
        .regRdValid(regRdValid));

    ////////////////////////////////////////////////////////////////////////////////
    // clock, random source and expectation helpers
    always #2.5 sys_clk = ~sys_clk;

    function [31:0] nx(input [31:0] s);
        nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function f(input b, input on, input off);
        f = on | (!off & b);
    endfunction

    // expected {duplex, activity, speed, link} after override and shaping
    function [3:0] expInd(input [15:0] k, input bic, input ls, input as, input ss, input ds);
        expInd = {f(ds, k[7], k[6]), f(as, k[5], k[4]), f(ss, k[3], k[2]),
                  f(bic ? ls & !as : ls, k[1], k[0])};
    endfunction

    task results;
    begin
        $display("errors %0d checks %0d", n_errors, n_checks);
        if (n_errors == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
    endtask

    task chk(input [15:0] got, input [15:0] exp);
    begin
        n_checks = n_checks + 1;
        if (got !== exp)
        begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            n_errors = n_errors + 1;
        end
    end
    endtask

    // read through the model; a missing answer ends the run
    task rdc(input [4:0] a, input [15:0] exp);
    begin
        mm.rd(a, d, ok);
        if (!ok)
        begin
            n_errors = n_errors + 1;
            results;
        end
        else
            chk(d, exp);
    end
    endtask

    // random event pulses at 100M, expected false carrier and disconnect counts saturate at 15
    task evts(input integer n);
    begin
        repeat (n)
        begin
            @(posedge sys_clk);
            r = nx(r);
            speed100 <= 1'b1;
            {disconnectEvent, falseCarrierEvent, rxErrorEvent} <= r[2:0];
            er = er + r[0];
            if (r[1] && fc < 15) fc = fc + 1;
            if (r[2] && dc < 15) dc = dc + 1;
        end
        @(posedge sys_clk);
        {disconnectEvent, falseCarrierEvent, rxErrorEvent} <= 3'h0;
    end
    endtask

    // carrier inputs wander every cycle
    always @(posedge sys_clk)
    begin
        rc = nx(rc);
        {carrierSense, rxDataValid} <= rc[1:0];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        sys_clk = 1'b0;
        rst_n = 1'b0;
        {speed100, bicolorMode, carrierSense, rxDataValid} = 4'h0;
        {linkStatus, activityStatus, speedStatus, duplexStatus} = 4'h0;
        {rxErrorEvent, falseCarrierEvent, disconnectEvent, disconnectFlagRead} = 4'h0;
        r = 32'h0001_04FA;
        rc = ~r;
        n_errors = 0;
        n_checks = 0;
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        rdc(5'h14, 16'h0000);
        rdc(5'h15, 16'h0000);
        mm.wr(5'h03, 16'hFFFF);
        rdc(5'h03, 16'h0000);
        mm.wr(5'h14, 16'hFFFF);
        rdc(5'h14, 16'h1FFF);
        chk({10'h000, fifoDepth}, 16'h0010);
        mm.wr(5'h14, 16'h0000);
        repeat (2) @(posedge sys_clk);
        chk({10'h000, fifoDepth}, 16'h0020);
        // overrides and automatic bicolor against random status
        for (i = 0; i < 32; i = i + 1)
        begin
            r = nx(r);
            c = {3'h0, r[12:11], 3'h0, r[7:0]};
            @(posedge sys_clk);
            {speed100, bicolorMode, linkStatus, activityStatus, speedStatus, duplexStatus}
                <= r[21:16];
            mm.wr(5'h14, c);
            repeat (2) @(posedge sys_clk);
            chk({12'h000, duplexIndicator, activityIndicator, speedIndicator, linkIndicator},
                {12'h000, expInd(c, r[20], r[19], r[18], r[17], r[16])});
        end
        // forced bicolor flashing: 16 high cycles in two full periods
        @(posedge sys_clk);
        bicolorMode <= 1'b1;
        mm.wr(5'h14, 16'h0700);
        repeat (2) @(posedge sys_clk);
        na = 0;
        nl = 0;
        repeat (32)
        begin
            @(posedge sys_clk);
            na = na + activityIndicator;
            nl = nl + linkIndicator;
        end
        chk({na[7:0], nl[7:0]}, 16'h1010);
        // sixteen-bit counting, then eight-bit fields
        rdc(5'h15, 16'h0000);
        er = 0;
        fc = 0;
        dc = 0;
        evts(40);
        rdc(5'h15, er[15:0]);
        rdc(5'h15, 16'h0000);
        mm.wr(5'h15, 16'h0001);
        er = 0;
        fc = 0;
        dc = 0;
        evts(60);
        rdc(5'h15, {dc[3:0], fc[3:0], er[7:0]});
        rdc(5'h15, 16'h0000);
        chk({15'h0000, disconnectFlag}, {15'h0000, dc != 0});
        // flag read clears the latched disconnect
        @(posedge sys_clk);
        disconnectFlagRead <= 1'b1;
        @(posedge sys_clk);
        disconnectFlagRead <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk({15'h0000, disconnectFlag}, 16'h0000);
        results;
    end
endmodule // tb_top

bind port_led_fifo_cfg port_led_fifo_cfg_assertions chk_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .regAddr(regAddr), .regWrEn(regWrEn), .regRdEn(regRdEn), .regWrData(regWrData),
    .regRdData(regRdData), .regRdValid(regRdValid), .speed100(speed100),
    .bicolorMode(bicolorMode), .carrierSense(carrierSense), .rxDataValid(rxDataValid),
    .activityStatus(activityStatus), .disconnectEvent(disconnectEvent),
    .rxCarrierValidOut(rxCarrierValidOut), .fifoDepthSelect(fifoDepthSelect),
    .fifoDepth(fifoDepth), .linkIndicator(linkIndicator),
    .activityIndicator(activityIndicator), .speedIndicator(speedIndicator),
    .duplexIndicator(duplexIndicator), .disconnectFlag(disconnectFlag));
